//--- logic/mi_indexer.sv
// Notes on behaviour
// - Two selects pick full down to 1/32
// - Low select has low, high, undriven
// - Selects sampled on each step rise
// - Format change lands on next valid state
// - Home at 45 degrees after wake
// - One table state per step rise
// - Direction high ascends, low descends
// - Positive level drives pos over neg
// - 128 states, coarser formats skip entries
// - Sleep kills bridges, pump, rail, logic
// - Inputs ignored while asleep
// - Fault low until supplies settle, 1 ms
// - Output disable leaves indexer running
// - Rising current forces slow decay
// - Supply lockout resets, holds fault low
`default_nettype none
module mi_indexer #(
    parameter int unsigned READY_CYC = mi_pkg::PWRUP_CYC // Settle cycles, shorten in simulation
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic [7:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    output var logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic step_i,
    input wire logic dir_i,
    input wire logic format_select_high_i,
    input wire logic format_select_low_i,
    input wire logic format_select_low_z_i,
    input wire logic sleep_request_n_i,
    input wire logic output_disable_n_i,
    input wire logic supply_low_lockout_i,
    input wire logic [2:0] decay_select_a_i,
    output var mi_pkg::mi_coil_s coil_o,
    output var logic [1:0] winding_out_pos_o,
    output var logic [1:0] winding_out_neg_o,
    output var logic bridge_en_o,
    output var logic [2:0] decay_mode_a_o,
    output var logic charge_pump_en_o,
    output var logic internal_rail_en_o,
    output var logic fault_flag_n_o,
    output var logic irq_o
);
    import mi_pkg::*;

    // ******
    // Helpers
    // ******
    // Pin levels to step format
    function automatic mi_fmt_e fmt_decode(input logic hi, input logic lo, input logic lo_z);
        logic [2:0] c;
        c = (hi ? 3'h3 : 3'h0) + (lo_z ? 3'h2 : {2'b00, lo});
        return mi_fmt_e'(c);
    endfunction
    // Index distance of one step
    function automatic logic [6:0] fmt_size(input mi_fmt_e f);
        unique case (f)
            MI_FULL: return 7'h20;
            MI_HALF: return 7'h10;
            MI_QUARTER: return 7'h08;
            MI_EIGHTH: return 7'h04;
            MI_SIXTEENTH: return 7'h02;
            default: return 7'h01;
        endcase
    endfunction
    // Signed sine percent of an index
    function automatic logic signed [7:0] sin_pct(input logic [6:0] i);
        logic [5:0] r;
        logic [6:0] m;
        r = i[5] ? 6'(6'h20 - {1'b0, i[4:0]}) : {1'b0, i[4:0]};
        m = QSIN[r];
        return i[6] ? -$signed({1'b0, m}) : $signed({1'b0, m});
    endfunction
    // Next grid point of a format; off-grid indexes snap toward travel
    function automatic logic [6:0] next_step(input logic [6:0] i, input mi_fmt_e f, input logic fwd);
        logic [6:0] base;
        logic [6:0] sz;
        logic [6:0] rel;
        logic [6:0] grid;
        base = (f == MI_FULL) ? FULL_OFS : 7'h00;
        sz = fmt_size(f);
        rel = i - base;
        grid = rel & ~(sz - 7'h01);
        if (fwd) begin
            return base + grid + sz;
        end
        return (grid == rel) ? base + grid - sz : base + grid;
    endfunction
    // Magnitude of a signed level
    function automatic logic [6:0] mag(input logic signed [7:0] v);
        return v[7] ? 7'(-v) : v[6:0];
    endfunction

    // ******
    // Pin synchronisers
    // ******
    logic [10:0] pin_meta; // First stage, read only by the second
    logic [10:0] pin_s; // Second stage
    logic step_q; // Step level one cycle back
    logic supply_low_lockout_q; // Lockout level one cycle back

    // All pins are asynchronous to the core clock
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            pin_meta <= 11'h000;
            pin_s <= 11'h000;
            supply_low_lockout_q <= 1'b0;
        end else begin
            pin_meta <= {decay_select_a_i, supply_low_lockout_i, output_disable_n_i, sleep_request_n_i,
                format_select_low_z_i, format_select_low_i, format_select_high_i, dir_i, step_i};
            pin_s <= pin_meta;
            supply_low_lockout_q <= pin_s[7]; // Lockout history, cleared by reset, not by the core clear
        end
    end

    logic step_s;
    logic dir_s;
    logic sleep_n_s;
    logic dis_s;
    logic supply_low_lockout_s;
    logic [2:0] decay_s;
    assign step_s = pin_s[0];
    assign dir_s = pin_s[1];
    assign sleep_n_s = pin_s[5];
    assign dis_s = pin_s[6];
    assign supply_low_lockout_s = pin_s[7];
    assign decay_s = pin_s[10:8];
    // Sleep and lockout clear the core like a reset
    logic core_clr;
    assign core_clr = !rstn_i || !sleep_n_s || supply_low_lockout_s;
    // Edge history
    always_ff @(posedge mclk_i) begin
        if (core_clr) begin
            step_q <= 1'b0;
        end else begin
            step_q <= step_s;
        end
    end
    logic step_rise; // Step edge taken
    mi_fmt_e fmt_now; // Format on the select pins
    assign step_rise = step_s && !step_q && !core_clr;
    assign fmt_now = fmt_decode(pin_s[2], pin_s[3], pin_s[4]);

    // ******
    // Power sequencer
    // ******
    mi_pwr_e pwr;
    logic [CNT_W-1:0] settle_cnt;
    // Rail and pump come up on wake, fault held until settled
    always_ff @(posedge mclk_i) begin
        if (core_clr) begin
            pwr <= PW_OFF;
            settle_cnt <= '0;
        end else begin
            unique case (pwr)
                PW_OFF: pwr <= PW_SETTLE;
                PW_SETTLE: begin
                    settle_cnt <= settle_cnt + 1'b1;
                    if (settle_cnt == CNT_W'(READY_CYC - 1)) begin
                        pwr <= PW_RUN;
                    end
                end
                PW_RUN: pwr <= PW_RUN;
                default: pwr <= PW_OFF;
            endcase
        end
    end

    // ******
    // Indexer
    // ******
    logic [6:0] idx; // Table index, 0 is 0 degrees
    mi_fmt_e fmt; // Format used by last step
    logic [6:0] prev_mag; // Winding A magnitude before last step
    logic signed [7:0] lvl_a;
    logic signed [7:0] lvl_b;
    assign lvl_a = sin_pct(idx + 7'h20); // Cosine
    assign lvl_b = sin_pct(idx);

    // Selects captured on the same edge that moves the index
    always_ff @(posedge mclk_i) begin
        if (core_clr) begin
            idx <= HOME_IDX;
            fmt <= FMT_RST;
            prev_mag <= mag(sin_pct(HOME_IDX));
        end else if (step_rise) begin
            fmt <= fmt_now;
            idx <= next_step(idx, fmt_now, dir_s);
            prev_mag <= mag(lvl_a);
        end
    end

    logic a_rising; // Winding A current grew on last step
    assign a_rising = mag(lvl_a) > prev_mag;

    // ******
    // Registers
    // ******
    logic ctrl_off; // Software bridge off
    logic [EV_W-1:0] irq_stat;
    logic [EV_W-1:0] irq_mask;
    logic [EV_W-1:0] ev;
    logic wr_en;
    logic setup;
    logic err_q;
    assign wr_en = psel_i && penable_i && pwrite_i;
    assign setup = psel_i && !penable_i;
    assign pready_o = 1'b1; // Zero wait states
    assign pslverr_o = psel_i && penable_i && err_q;

    always_comb begin
        ev = '0;
        ev[EV_STEP] = step_rise;
        ev[EV_FMT] = step_rise && (fmt_now != fmt);
        ev[EV_READY] = (pwr == PW_SETTLE) && (settle_cnt == CNT_W'(READY_CYC - 1)) && !core_clr;
        ev[EV_LOCK] = supply_low_lockout_s && !supply_low_lockout_q;
    end

    // Control and mask
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            ctrl_off <= CTRL_RST;
            irq_mask <= MASK_RST;
        end else if (wr_en && paddr_i == CTRL_OFS) begin
            ctrl_off <= pwdata_i[CTRL_OFF_BIT];
        end else if (wr_en && paddr_i == IRQ_MASK_OFS) begin
            irq_mask <= pwdata_i[EV_W-1:0];
        end
    end

    // Sticky events; a new event beats a clear in the same cycle
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            irq_stat <= '0;
            irq_o <= 1'b0;
        end else begin
            if (wr_en && paddr_i == IRQ_STAT_OFS) begin
                irq_stat <= (irq_stat & ~pwdata_i[EV_W-1:0]) | ev;
                irq_o <= |(((irq_stat & ~pwdata_i[EV_W-1:0]) | ev) & irq_mask);
            end else begin
                irq_stat <= irq_stat | ev;
                irq_o <= |((irq_stat | ev) & irq_mask);
            end
        end
    end

    mi_state_s st;
    mi_coil_s lvl_now;
    always_comb begin
        st = '0;
        st.idx = idx;
        st.fmt = fmt;
        st.pwr = pwr;
        st.bridge = bridge_en_o;
        st.fault_n = fault_flag_n_o;
        st.dir = dir_s;
        st.sleep_n = sleep_n_s;
        lvl_now = '{a: lvl_a, b: lvl_b};
    end

    // Read data latched in setup so it stands through access
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            prdata_o <= 32'h0000_0000;
            err_q <= 1'b0;
        end else if (setup) begin
            err_q <= 1'b0;
            unique case (paddr_i)
                CTRL_OFS: prdata_o <= {31'h0, ctrl_off};
                STATE_OFS: prdata_o <= st;
                IRQ_STAT_OFS: prdata_o <= {28'h0, irq_stat};
                IRQ_MASK_OFS: prdata_o <= {28'h0, irq_mask};
                LEVEL_OFS: prdata_o <= {16'h0, lvl_now};
                default: begin
                    prdata_o <= 32'h0000_0000;
                    err_q <= 1'b1;
                end
            endcase
        end
    end

    // ******
    // Output stage
    // ******
    logic next_en; // Bridge drive allowed
    assign next_en = (pwr == PW_RUN) && !dis_s && !ctrl_off;

    // Levels and drive follow the index one cycle later
    always_ff @(posedge mclk_i) begin
        if (core_clr) begin
            coil_o <= '{a: 8'sh00, b: 8'sh00};
            winding_out_pos_o <= 2'h0;
            winding_out_neg_o <= 2'h0;
            bridge_en_o <= 1'b0;
            decay_mode_a_o <= SLOW_DECAY;
        end else begin
            coil_o <= lvl_now;
            winding_out_pos_o <= {next_en && lvl_b > 0, next_en && lvl_a > 0};
            winding_out_neg_o <= {next_en && lvl_b < 0, next_en && lvl_a < 0};
            bridge_en_o <= next_en;
            decay_mode_a_o <= a_rising ? SLOW_DECAY : decay_s;
        end
    end

    // Supplies and fault pin
    always_ff @(posedge mclk_i) begin
        if (core_clr) begin
            charge_pump_en_o <= 1'b0;
            internal_rail_en_o <= 1'b0;
            fault_flag_n_o <= 1'b0;
        end else begin
            charge_pump_en_o <= 1'b1;
            internal_rail_en_o <= 1'b1;
            fault_flag_n_o <= (pwr == PW_RUN);
        end
    end

    // ******
    // Checks
    // ******
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    chk_fmt_capture: assert property (step_rise |=> fmt == $past(fmt_now))
        else $error("format not captured on step");
    chk_z_level: assert property (step_rise && pin_s[2] && pin_s[4] |=> fmt == MI_32ND)
        else $error("undriven low select misdecoded");
    chk_on_grid: assert property (step_rise |=>
        ((fmt == MI_FULL) ? (idx[4:0] == 5'h10) : ((idx & (fmt_size(fmt) - 7'h01)) == 7'h00)))
        else $error("step left the format grid");
    chk_step_fwd: assert property (step_rise && dir_s && fmt_now == MI_32ND |=> idx == $past(idx) + 7'h01)
        else $error("forward step size wrong");
    chk_step_back: assert property (step_rise && !dir_s && fmt_now == MI_HALF && idx[3:0] == 4'h0
        |=> idx == $past(idx) - 7'h10)
        else $error("backward step wrong");
    chk_home_state: assert property (core_clr |=> idx == HOME_IDX && lvl_a == 8'sh47 && lvl_b == 8'sh47)
        else $error("home state not entered");
    chk_sleep_off: assert property (!sleep_n_s |=> !bridge_en_o && !charge_pump_en_o && !internal_rail_en_o)
        else $error("sleep left circuitry on");
    chk_sleep_deaf: assert property (!sleep_n_s ##1 !sleep_n_s ##1 !sleep_n_s |-> $stable(idx) && !step_rise)
        else $error("input acted on during sleep");
    chk_fault_hold: assert property ($rose(sleep_n_s) && rstn_i |=> ##2 !fault_flag_n_o)
        else $error("fault released too early");
    chk_fault_free: assert property ($rose(pwr == PW_RUN) |=> fault_flag_n_o)
        else $error("fault not released when settled");
    chk_disable_runs: assert property (step_rise && dis_s |=> !bridge_en_o && idx != $past(idx))
        else $error("disable stopped the indexer");
    chk_slow_rise: assert property (a_rising && !core_clr |=> decay_mode_a_o == SLOW_DECAY)
        else $error("rising current not slow decay");
    chk_lockout: assert property (supply_low_lockout_s |=> !fault_flag_n_o && idx == HOME_IDX)
        else $error("lockout did not reset");
    chk_polarity: assert property (bridge_en_o && coil_o.a > 0 |-> winding_out_pos_o[0] && !winding_out_neg_o[0])
        else $error("winding polarity wrong");

    cov_wrap: cover property (step_rise && dir_s && idx == 7'h7F ##1 idx == 7'h00);
    cov_fmt_change: cover property (ev[EV_FMT]);
    cov_ready: cover property ($rose(fault_flag_n_o));
endmodule
`default_nettype wire

//--- logic/mi_pkg.sv
`default_nettype none
package mi_pkg;
    // ******
    // Timing
    // ******
    localparam int unsigned CLK_NS = 100; // Core clock period, 10 MHz
    localparam int unsigned PWRUP_NS = 1000000; // Supply settle time, 1 ms
    localparam int unsigned PWRUP_CYC = PWRUP_NS / CLK_NS; // Longest time, rounds down
    localparam int unsigned CNT_W = 14; // Settle counter width

    // ******
    // Step table
    // ******
    localparam logic [6:0] HOME_IDX = 7'h10; // 45 degrees, both windings 71%
    localparam logic [6:0] FULL_OFS = 7'h10; // Full step grid sits on odd 45s
    // Quarter wave of the sine, percent, index 0..32
    localparam logic [6:0] QSIN [0:32] = '{7'h00, 7'h05, 7'h0A, 7'h0F, 7'h14, 7'h18, 7'h1D, 7'h22, 7'h26,
        7'h2B, 7'h2F, 7'h33, 7'h38, 7'h3C, 7'h3F, 7'h43, 7'h47, 7'h4A, 7'h4D, 7'h50, 7'h53, 7'h56, 7'h58,
        7'h5A, 7'h5C, 7'h5E, 7'h60, 7'h61, 7'h62, 7'h63, 7'h64, 7'h64, 7'h64};
    localparam logic [2:0] SLOW_DECAY = 3'h0; // Decay code for slow decay

    // ******
    // Registers
    // ******
    localparam logic [7:0] CTRL_OFS = 8'h00; // Control
    localparam logic [7:0] STATE_OFS = 8'h04; // Indexer state, read only
    localparam logic [7:0] IRQ_STAT_OFS = 8'h08; // Sticky events, write one to clear
    localparam logic [7:0] IRQ_MASK_OFS = 8'h0C; // Event mask
    localparam logic [7:0] LEVEL_OFS = 8'h10; // Winding levels, read only
    localparam int unsigned CTRL_OFF_BIT = 0; // Software bridge off
    localparam int unsigned EV_W = 4; // Event count
    localparam int unsigned EV_STEP = 0; // Step taken
    localparam int unsigned EV_FMT = 1; // Format changed on a step
    localparam int unsigned EV_READY = 2; // Supplies settled
    localparam int unsigned EV_LOCK = 3; // Supply lockout entered
    localparam logic CTRL_RST = 1'b0; // Bridges allowed after reset
    localparam logic [3:0] MASK_RST = 4'h0; // All events masked after reset

    // ******
    // Types
    // ******
    typedef enum logic [2:0] {
        MI_FULL = 3'b000, MI_HALF = 3'b001, MI_QUARTER = 3'b010,
        MI_EIGHTH = 3'b011, MI_SIXTEENTH = 3'b100, MI_32ND = 3'b101
    } mi_fmt_e;
    localparam mi_fmt_e FMT_RST = MI_FULL; // Format after reset
    typedef enum logic [1:0] {PW_OFF = 2'b00, PW_SETTLE = 2'b01, PW_RUN = 2'b10} mi_pwr_e;
    typedef struct packed {
        logic signed [7:0] a; // Winding A, percent
        logic signed [7:0] b; // Winding B, percent
    } mi_coil_s;
    typedef struct packed {
        logic [11:0] rsvd0;
        logic sleep_n;
        logic dir;
        logic fault_n;
        logic bridge;
        logic [1:0] rsvd1;
        logic [1:0] pwr;
        logic rsvd2;
        logic [2:0] fmt;
        logic rsvd3;
        logic [6:0] idx;
    } mi_state_s;
endpackage
`default_nettype wire

//--- dv/mi_ctrl_model.sv
`default_nettype none
// ******
// Controller model: step, direction and format pins
// ******
module mi_ctrl_model (
    input wire logic mclk_i,
    input wire logic fault_flag_n_i,
    output logic step_o,
    output logic dir_o,
    output logic format_select_high_o,
    output logic format_select_low_o,
    output logic format_select_low_z_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pins idle low at time zero, except direction, which starts high
    initial begin
        step_o = 1'b0;
        dir_o = 1'b1;
        format_select_high_o = 1'b0;
        format_select_low_o = 1'b0;
        format_select_low_z_o = 1'b0;
    end
    // Code 0..5; a floated low select flips its stale level so it is never trusted
    task automatic set_fmt(input int c, input logic d);
        @(posedge mclk_i);
        format_select_high_o <= (c >= 3);
        format_select_low_z_o <= (c % 3 == 2);
        format_select_low_o <= (c % 3 == 2) ? ~format_select_low_o : (c % 3 == 1);
        dir_o <= d;
    endtask
    // High and low held four clocks each, above the two-clock minimum
    task automatic pulse();
        @(posedge mclk_i);
        step_o <= 1'b1;
        repeat (4) @(posedge mclk_i);
        step_o <= 1'b0;
        repeat (4) @(posedge mclk_i);
    endtask
    // Holds off stepping until the fault flag is released
    task automatic wait_ready(output logic ok);
        int n;
        ok = 1'b0;
        for (n = 0; n < 200 && !ok; n++) begin
            @(posedge mclk_i);
            ok = (fault_flag_n_i === 1'b1);
        end
    endtask
endmodule
`default_nettype wire

//--- dv/microstep_indexer_tb.sv
`default_nettype none
module microstep_indexer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import mi_pkg::*;
    // ******
    // Signals
    // ******
    // Last entry is a half step down from an on-grid index
    localparam int CD[13] = '{0, 1, 2, 3, 4, 5, 0, 0, 5, 0, 0, 0, 1}; // Format codes
    localparam int DR[13] = '{1, 1, 1, 1, 1, 1, 1, 0, 0, 0, 0, 1, 0}; // Directions
    localparam int EX[13] = '{48, 64, 72, 76, 78, 79, 80, 48, 47, 16, 112, 16, 0}; // Expected index
    logic mclk_i, rstn_i, psel, penable, pwrite, pready, pslverr, ok;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic step, dir, fh, fl, flz, sleep_n, odis_n, lock, bridge, pump, rail, fault_n, irq, rerr;
    logic [2:0] dsel, dmode;
    logic [1:0] pos, neg;
    mi_coil_s coil;
    int failures, total_checks;
    mi_indexer #(.READY_CYC(20)) u_mi_indexer (.mclk_i(mclk_i), .rstn_i(rstn_i), .paddr_i(paddr),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .step_i(step), .dir_i(dir), .format_select_high_i(fh),
        .format_select_low_i(fl), .format_select_low_z_i(flz), .sleep_request_n_i(sleep_n),
        .output_disable_n_i(odis_n), .supply_low_lockout_i(lock), .decay_select_a_i(dsel), .coil_o(coil),
        .winding_out_pos_o(pos), .winding_out_neg_o(neg), .bridge_en_o(bridge), .decay_mode_a_o(dmode),
        .charge_pump_en_o(pump), .internal_rail_en_o(rail), .fault_flag_n_o(fault_n), .irq_o(irq));
    mi_ctrl_model u_mi_ctrl_model (.mclk_i(mclk_i), .fault_flag_n_i(fault_n), .step_o(step), .dir_o(dir),
        .format_select_high_o(fh), .format_select_low_o(fl), .format_select_low_z_o(flz));
    // 10 MHz core clock
    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end
    // ******
    // Tasks
    // ******
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk_i);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            give_verdict();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic mv(input int c, input logic d);
        u_mi_ctrl_model.set_fmt(c, d);
        u_mi_ctrl_model.pulse();
    endtask
    task automatic wake_home();
        u_mi_ctrl_model.wait_ready(ok);
        chk("fault release", 32'(ok), 1);
        // A fault flag that never lifts ends the run here
        if (ok !== 1'b1) begin
            give_verdict();
        end
        apb(1'b0, STATE_OFS, 0);
        chk("home index", 32'(rdat[6:0]), 32'(HOME_IDX));
    endtask
    // ******
    // Main sequence
    // ******
    initial begin
        {rstn_i, psel, penable, pwrite, lock, odis_n} = 6'h00;
        {paddr, pwdata, sleep_n, dsel} = {8'h00, 32'h0, 1'b1, 3'h2};
        failures = 0;
        total_checks = 0;
        repeat (10) @(posedge mclk_i);
        rstn_i <= 1'b1;
        wake_home();
        apb(1'b0, LEVEL_OFS, 0);
        chk("home level", rdat, 32'h4747);
        chk("home drive", 32'({pos, neg}), 32'hC);
        $display("test power-up done");
        // Every format, off-grid changes, both directions, both wraps
        for (int i = 0; i < 13; i++) begin
            mv(CD[i], DR[i][0]);
            apb(1'b0, STATE_OFS, 0);
            chk("step format", 32'(rdat[10:8]), 32'(CD[i][2:0]));
            chk("step index", 32'(rdat[6:0]), 32'(EX[i][6:0]));
        end
        $display("test format walk done");
        // Bridge off must not stop the indexer
        odis_n <= 1'b1;
        mv(0, 1'b0);
        apb(1'b0, STATE_OFS, 0);
        chk("disabled step", 32'(rdat[6:0]), 112);
        chk("disabled drive", 32'({bridge, pos, neg}), 0);
        apb(1'b0, LEVEL_OFS, 0);
        // Index 112 sits at 315 degrees: A +71, B -71
        chk("level 315", rdat, 32'h47B9);
        chk("coil 315", 32'(coil), 32'h47B9);
        odis_n <= 1'b0;
        repeat (6) @(posedge mclk_i);
        chk("signed drive", 32'({pos, neg}), 32'h6);
        $display("test output disable done");
        // Step event masked, then unmasked, then cleared
        apb(1'b1, IRQ_STAT_OFS, 32'hF);
        mv(5, 1'b1);
        chk("rising decay", 32'(dmode), 32'(SLOW_DECAY));
        apb(1'b0, IRQ_STAT_OFS, 0);
        chk("step event", 32'({rdat[0], irq}), 32'h2);
        apb(1'b1, IRQ_MASK_OFS, 32'h1);
        repeat (3) @(posedge mclk_i);
        chk("irq raised", 32'(irq), 1);
        apb(1'b1, IRQ_STAT_OFS, 32'h1);
        repeat (3) @(posedge mclk_i);
        chk("irq cleared", 32'(irq), 0);
        mv(5, 1'b0);
        chk("falling decay", 32'(dmode), 32'h2);
        apb(1'b0, 8'h20, 0);
        chk("unmapped", 32'({rerr, rdat[0]}), 32'h2);
        $display("test events done");
        // Sleep with steps ignored, then wake to home
        sleep_n <= 1'b0;
        repeat (6) @(posedge mclk_i);
        chk("asleep", 32'({bridge, pump, rail, fault_n}), 0);
        mv(0, 1'b1);
        sleep_n <= 1'b1;
        repeat (5) @(posedge mclk_i);
        chk("wake fault", 32'(fault_n), 0);
        wake_home();
        $display("test sleep done");
        // Supply lockout resets like sleep
        mv(0, 1'b1);
        lock <= 1'b1;
        repeat (6) @(posedge mclk_i);
        chk("lockout fault", 32'(fault_n), 0);
        lock <= 1'b0;
        wake_home();
        $display("test lockout done");
        give_verdict();
    end
endmodule
`default_nettype wire
